// file: hdl/pa_mux_pkg.sv
// pa_mux_pkg: constants, register map and state type of the external
// amplifier pin-function mux.
// assumes: 32-bit AHB-Lite register bus, word-aligned registers.
package pa_mux_pkg;

    // ************************************************************
    // register indices and byte addresses
    // ************************************************************
    localparam logic [29:0] FUNC_SEL_INDEX  = 30'h00000026;
    localparam logic [29:0] SEQ_CTRL_INDEX  = 30'h00000028;
    localparam logic [29:0] STATUS_INDEX    = 30'h00000029;
    localparam logic [31:0] FUNC_SEL_ADDR   = {FUNC_SEL_INDEX, 2'b00};
    localparam logic [31:0] SEQ_CTRL_ADDR   = {SEQ_CTRL_INDEX, 2'b00};
    localparam logic [31:0] STATUS_ADDR     = {STATUS_INDEX, 2'b00};

    // ************************************************************
    // field layout and reset values
    // ************************************************************
    localparam int          AMP_SEL_LSB     = 14;
    localparam int          TX_SEL_LSB      = 16;
    localparam logic [1:0]  SEL_GPIO        = 2'h0;
    localparam logic [1:0]  SEL_DEDICATED   = 2'h1;
    localparam logic [31:0] FUNC_SEL_RESET  = 32'h00000000;
    localparam logic [31:0] ENABLE_MASK     = 32'h00014000;
    localparam int          SEQ_EN_BIT      = 0;
    localparam logic        SEQ_EN_RESET    = 1'h1;
    localparam int          STAT_AMP_BIT    = 2;
    localparam int          STAT_TXACT_BIT  = 3;
    localparam int          STAT_PIN_LSB    = 4;
    localparam int          STAT_CNT_LSB    = 16;
    localparam int          COUNT_W         = 16;

    // ************************************************************
    // ahb encodings
    // ************************************************************
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic        HRESP_OKAY      = 1'h0;

    // ************************************************************
    // radio state, gray along idle-tx and idle-rx
    // ************************************************************
    typedef enum logic [1:0] {
        RADIO_IDLE = 2'h0,
        RADIO_TX   = 2'h1,
        RADIO_RX   = 2'h2
    } radio_state_t;

endpackage

// file: hdl/ext_pa_pin_function_mux.sv
// ext_pa_pin_function_mux: pin-function select register behind ahb-lite
// and the two pins that drive an external amplifier and rf switches.
// assumes: radio core gives tx/rx levels and a frame-done pulse; the
// gpio block supplies plain-mode pin data and direction.
`timescale 1ns/100ps
`default_nettype none

module ext_pa_pin_function_mux (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        radio_tx_on,
    input  wire logic        radio_rx_on,
    input  wire logic        tx_frame_done,
    input  wire logic [1:0]  gpio_out_data,
    input  wire logic [1:0]  gpio_out_en_n,
    output logic [1:0]       gpio_in_data,
    input  wire logic        path_steer_pin_i,
    output logic             path_steer_pin_o,
    output logic             path_steer_pin_oe_n,
    input  wire logic        tx_enable_pin_i,
    output logic             tx_enable_pin_o,
    output logic             tx_enable_pin_oe_n,
    output logic             amp_enable_out,
    output logic             tx_active_out,
    output logic             fine_seq_enable
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [31:0]                 func_sel;
        logic                        seq_en;
        pa_mux_pkg::radio_state_t    radio;
        logic [pa_mux_pkg::COUNT_W-1:0] amp_count;
        logic                        dp_write;
        logic [31:0]                 dp_addr;
        logic [31:0]                 rdata;
        logic                        amp;
        logic                        txact;
        logic [1:0]                  pin_o;
        logic [1:0]                  pin_oe_n;
        logic [1:0]                  pin_in;
    } state_t;

    state_t s_reg;
    state_t s_next;

    localparam state_t STATE_RESET = '{
        func_sel:  pa_mux_pkg::FUNC_SEL_RESET,
        seq_en:    pa_mux_pkg::SEQ_EN_RESET,
        radio:     pa_mux_pkg::RADIO_IDLE,
        amp_count: '0,
        dp_write:  1'b0,
        dp_addr:   32'h00000000,
        rdata:     32'h00000000,
        amp:       1'b0,
        txact:     1'b0,
        pin_o:     2'h0,
        pin_oe_n:  2'h3,
        pin_in:    2'h0
    };

    // ************************************************************
    // functions
    // ************************************************************
    // a reserved code falls back to plain gpio: safer than a stuck pin
    function automatic logic [1:0] pin_drive(
        input logic [1:0] sel,
        input logic       func_val,
        input logic       gpio_val,
        input logic       gpio_oe_n
    );
        if (sel == pa_mux_pkg::SEL_DEDICATED) begin
            pin_drive = {1'b0, func_val};
        end else begin
            pin_drive = {gpio_oe_n, gpio_val};
        end
    endfunction

    function automatic logic [31:0] read_mux(
        input logic [31:0] addr,
        input state_t      st
    );
        read_mux = 32'h00000000;
        if (addr == pa_mux_pkg::FUNC_SEL_ADDR) begin
            read_mux = st.func_sel;
        end else if (addr == pa_mux_pkg::SEQ_CTRL_ADDR) begin
            read_mux[pa_mux_pkg::SEQ_EN_BIT] = st.seq_en;
        end else if (addr == pa_mux_pkg::STATUS_ADDR) begin
            read_mux[1:0] = st.radio;
            read_mux[pa_mux_pkg::STAT_AMP_BIT] = st.amp;
            read_mux[pa_mux_pkg::STAT_TXACT_BIT] = st.txact;
            read_mux[pa_mux_pkg::STAT_PIN_LSB +: 2] = st.pin_in;
            read_mux[pa_mux_pkg::STAT_CNT_LSB +: pa_mux_pkg::COUNT_W] =
                st.amp_count;
        end
    endfunction

    // ************************************************************
    // next state
    // ************************************************************
    logic       addr_phase;
    logic [1:0] amp_pin;
    logic [1:0] tx_pin;

    always_comb begin
        s_next = s_reg;
        amp_pin = 2'h0;
        tx_pin = 2'h0;
        addr_phase = hsel && hready && htrans == pa_mux_pkg::HTRANS_NONSEQ;

        // data phase of a write; only whole-word writes are expected
        if (s_reg.dp_write) begin
            if (s_reg.dp_addr == pa_mux_pkg::FUNC_SEL_ADDR) begin
                s_next.func_sel = hwdata;
            end else if (s_reg.dp_addr == pa_mux_pkg::SEQ_CTRL_ADDR) begin
                s_next.seq_en = hwdata[pa_mux_pkg::SEQ_EN_BIT];
            end
        end

        // address phase; read data sees a write in the same cycle
        s_next.dp_write = addr_phase && hwrite;
        if (addr_phase) begin
            s_next.dp_addr = haddr;
            if (!hwrite) begin
                s_next.rdata = read_mux(haddr, s_next);
            end
        end

        // radio state; frame-done forces a gap so the amp turns on anew
        if (tx_frame_done) begin
            s_next.radio = pa_mux_pkg::RADIO_IDLE;
        end else if (radio_tx_on) begin
            s_next.radio = pa_mux_pkg::RADIO_TX;
        end else if (radio_rx_on) begin
            s_next.radio = pa_mux_pkg::RADIO_RX;
        end else begin
            s_next.radio = pa_mux_pkg::RADIO_IDLE;
        end

        // functions follow the radio with no software action
        s_next.amp = s_next.radio == pa_mux_pkg::RADIO_TX;
        s_next.txact = s_next.radio == pa_mux_pkg::RADIO_TX;
        if (s_next.amp && !s_reg.amp) begin
            s_next.amp_count = s_reg.amp_count + 1'b1;
        end

        // pin muxes
        // registered so a mode write can never glitch the amplifier enable
        amp_pin = pin_drive(
            s_next.func_sel[pa_mux_pkg::AMP_SEL_LSB +: 2], s_next.amp,
            gpio_out_data[0], gpio_out_en_n[0]);
        tx_pin = pin_drive(
            s_next.func_sel[pa_mux_pkg::TX_SEL_LSB +: 2], s_next.txact,
            gpio_out_data[1], gpio_out_en_n[1]);
        s_next.pin_o = {tx_pin[0], amp_pin[0]};
        s_next.pin_oe_n = {tx_pin[1], amp_pin[1]};
        s_next.pin_in = {tx_enable_pin_i, path_steer_pin_i};
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= STATE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // zero wait: every register answers from flops, no stall is needed
    assign hreadyout = 1'b1;
    assign hresp = pa_mux_pkg::HRESP_OKAY;
    assign hrdata = s_reg.rdata;
    assign gpio_in_data = s_reg.pin_in;
    assign path_steer_pin_o = s_reg.pin_o[0];
    assign path_steer_pin_oe_n = s_reg.pin_oe_n[0];
    assign tx_enable_pin_o = s_reg.pin_o[1];
    assign tx_enable_pin_oe_n = s_reg.pin_oe_n[1];
    assign amp_enable_out = s_reg.amp;
    assign tx_active_out = s_reg.txact;
    assign fine_seq_enable = s_reg.seq_en;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic amp_dedicated;
    logic tx_dedicated;
    assign amp_dedicated =
        s_reg.func_sel[pa_mux_pkg::AMP_SEL_LSB +: 2] ==
        pa_mux_pkg::SEL_DEDICATED;
    assign tx_dedicated =
        s_reg.func_sel[pa_mux_pkg::TX_SEL_LSB +: 2] ==
        pa_mux_pkg::SEL_DEDICATED;
    // bus checks look one cycle on: the bus never inserts a wait
    logic rd_phase;
    assign rd_phase = addr_phase && !hwrite;

    a_tx_amp_on: assert property (
        radio_tx_on && !tx_frame_done |=> amp_enable_out)
        else $error("amp enable not high during transmit");
    a_rx_amp_off: assert property (
        !radio_tx_on && radio_rx_on |=> !amp_enable_out &&
        (!amp_dedicated || !path_steer_pin_o))
        else $error("amp or steering high during receive");
    a_frame_gap: assert property (
        tx_frame_done |=> !amp_enable_out)
        else $error("amp not dropped at frame end");
    a_count_turnon: assert property (
        $rose(amp_enable_out) |->
        s_reg.amp_count == $past(s_reg.amp_count) + 1'b1)
        else $error("turn-on count not advanced");
    a_write_func: assert property (
        s_reg.dp_write && s_reg.dp_addr == pa_mux_pkg::FUNC_SEL_ADDR |=>
        s_reg.func_sel == $past(hwdata))
        else $error("function register write lost");
    a_amp_pin_mux: assert property (
        amp_dedicated |-> !path_steer_pin_oe_n &&
        path_steer_pin_o == amp_enable_out)
        else $error("amp pin not routed");
    a_tx_pin_mux: assert property (
        tx_dedicated |-> !tx_enable_pin_oe_n &&
        tx_enable_pin_o == (s_reg.radio == pa_mux_pkg::RADIO_TX))
        else $error("tx pin not routed");
    a_gpio_default: assert property (
        !tx_dedicated |=> tx_dedicated ||
        tx_enable_pin_oe_n == $past(gpio_out_en_n[1]))
        else $error("tx pin not plain gpio");
    a_auto_follow: assert property (
        tx_active_out ##1 !radio_tx_on && !radio_rx_on [*2] |->
        !tx_active_out && !amp_enable_out)
        else $error("outputs not following radio");

    a_read_func: assert property (
        rd_phase && haddr == pa_mux_pkg::FUNC_SEL_ADDR && !s_reg.dp_write
        |=> hrdata == s_reg.func_sel)
        else $error("function register read wrong");
    a_read_status: assert property (
        rd_phase && haddr == pa_mux_pkg::STATUS_ADDR |=>
        hrdata[pa_mux_pkg::STAT_CNT_LSB +: pa_mux_pkg::COUNT_W] ==
        s_reg.amp_count && hrdata[1:0] == s_reg.radio)
        else $error("status read wrong");
    a_seq_write: assert property (
        s_reg.dp_write && s_reg.dp_addr == pa_mux_pkg::SEQ_CTRL_ADDR |=>
        fine_seq_enable == $past(hwdata[pa_mux_pkg::SEQ_EN_BIT]))
        else $error("sequencing enable write lost");

    a_txact_low: assert property (
        !radio_tx_on || tx_frame_done |=> !tx_active_out)
        else $error("tx active high outside transmit");
    a_amp_idle_off: assert property (
        !radio_tx_on |=> !amp_enable_out)
        else $error("amp on while not transmitting");
    a_count_hold: assert property (
        !$rose(amp_enable_out) |-> $stable(s_reg.amp_count))
        else $error("turn-on count moved without a turn-on");
    a_steer_gpio: assert property (
        !amp_dedicated |=> amp_dedicated ||
        (path_steer_pin_oe_n == $past(gpio_out_en_n[0]) &&
        path_steer_pin_o == $past(gpio_out_data[0])))
        else $error("steering pin not plain gpio");

    c_tx_frame: cover property (
        amp_dedicated && $rose(amp_enable_out) ##[1:20] tx_frame_done);
    c_rx_after_tx: cover property (
        tx_active_out ##[1:20] s_reg.radio == pa_mux_pkg::RADIO_RX);
    c_enable_write: cover property (
        s_reg.dp_write && hwdata == pa_mux_pkg::ENABLE_MASK);
    c_gpio_drive: cover property (
        !amp_dedicated && $fell(path_steer_pin_oe_n));
    c_steer_rx: cover property (
        amp_dedicated && $fell(path_steer_pin_o) &&
        s_reg.radio == pa_mux_pkg::RADIO_RX);

endmodule

`default_nettype wire

// file: sim/pa_switch_model.sv
// pa_switch_model: external amplifier and the two rf path switches.
// assumes: pin levels are already resolved from the mux enables.
`timescale 1ns/100ps
`default_nettype none

module pa_switch_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        amp_ctrl,
    input  wire logic        route_ctrl,
    output logic             amp_powered,
    output logic             sw_rx_sel,
    output logic             sw_tx_sel,
    output logic [7:0]       turn_on_cnt
);
    logic amp_d;

    // ************************************************************
    // switch controls and amplifier
    // ************************************************************
    // tx select only ever comes from the inverted rx select
    assign sw_rx_sel   = ~route_ctrl;
    assign sw_tx_sel   = ~sw_rx_sel;
    assign amp_powered = amp_ctrl;

    // counts turn-on transients, one is expected per frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            amp_d       <= 1'b0;
            turn_on_cnt <= 8'h00;
        end else begin
            amp_d <= amp_ctrl;
            if (amp_ctrl && !amp_d) begin
                turn_on_cnt <= turn_on_cnt + 8'h01;
            end
        end
    end
endmodule

`default_nettype wire

// file: sim/ext_pa_pin_function_mux_tb.sv
// ext_pa_pin_function_mux_tb: bus-driven tests of the pin mux.
// assumes: single ahb-lite slave, pins pulled low when not driven.
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    n_mismatch++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end end

module ext_pa_pin_function_mux_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout, hresp;
    logic [31:0] hrdata, d;
    logic        tx_on = 1'b0, rx_on = 1'b0, done = 1'b0;
    logic [1:0]  g_dat = 2'h0, g_en_n = 2'h3, g_in, m;
    logic        st_o, st_oe_n, te_o, te_oe_n, st_w, te_w;
    logic        amp_out, txact, fseq, amp_pw, rx_sel, tx_sel;
    logic [7:0]  ons;
    int          n_mismatch = 0;
    int          num_checks = 0;

    always #50 hclk = ~hclk;
    // pull-downs: an undriven pin must not look like a held level
    assign st_w = st_oe_n ? 1'b0 : st_o;
    assign te_w = te_oe_n ? 1'b0 : te_o;

    ext_pa_pin_function_mux DUT (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .radio_tx_on(tx_on), .radio_rx_on(rx_on), .tx_frame_done(done),
        .gpio_out_data(g_dat), .gpio_out_en_n(g_en_n), .gpio_in_data(g_in),
        .path_steer_pin_i(st_w), .path_steer_pin_o(st_o),
        .path_steer_pin_oe_n(st_oe_n), .tx_enable_pin_i(te_w),
        .tx_enable_pin_o(te_o), .tx_enable_pin_oe_n(te_oe_n),
        .amp_enable_out(amp_out), .tx_active_out(txact),
        .fine_seq_enable(fseq));

    pa_switch_model partner (.clk(hclk), .rst_n(hresetn), .amp_ctrl(te_w),
        .route_ctrl(st_w), .amp_powered(amp_pw), .sw_rx_sel(rx_sel),
        .sw_tx_sel(tx_sel), .turn_on_cnt(ons));

    // ************************************************************
    // bus cycles and helpers
    // ************************************************************
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= pa_mux_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] wd);
        logic [31:0] x;
        bus(1'b1, a, wd, x);
    endtask

    task automatic tick();
        @(posedge hclk);
        #1;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, pa_mux_pkg::FUNC_SEL_ADDR, 32'h0, d);
        `CHK("func_sel reset", 32'h00000000, d)
        `CHK("hresp", 1'b0, hresp)
        bus(1'b0, pa_mux_pkg::SEQ_CTRL_ADDR, 32'h0, d);
        `CHK("seq reset", 32'h00000001, d)
        g_dat <= 2'h1;
        g_en_n <= 2'h2;
        tick();
        `CHK("gpio pins", 2'h1, {te_o, st_o})
        `CHK("gpio oe_n", 2'h2, {te_oe_n, st_oe_n})
        tick();
        `CHK("gpio in", 2'h1, g_in)
        g_en_n <= 2'h3;
        wr(pa_mux_pkg::FUNC_SEL_ADDR, 32'h00000003);
        bus(1'b0, pa_mux_pkg::FUNC_SEL_ADDR, 32'h0, d);
        wr(pa_mux_pkg::FUNC_SEL_ADDR, d | pa_mux_pkg::ENABLE_MASK);
        bus(1'b0, pa_mux_pkg::FUNC_SEL_ADDR, 32'h0, d);
        `CHK("func_sel rmw", 32'h00014003, d)
        wr(pa_mux_pkg::SEQ_CTRL_ADDR, 32'h0);
        tick();
        `CHK("fine seq", 1'b0, fseq)
        wr(32'h00000100, 32'hffffffff);
        bus(1'b0, 32'h00000100, 32'h0, d);
        `CHK("unmapped", 32'h00000000, d)
        tx_on <= 1'b1;
        tick();
        `CHK("tx amp/act", 2'h3, {amp_out, txact})
        `CHK("tx pins", 4'hc, {te_o, st_o, te_oe_n, st_oe_n})
        done <= 1'b1;
        tick();
        done <= 1'b0;
        `CHK("frame end", 3'h0, {amp_out, txact, te_w})
        tick();
        `CHK("next frame", 2'h3, {amp_out, txact})
        bus(1'b0, pa_mux_pkg::STATUS_ADDR, 32'h0, d);
        `CHK("status count", 16'h0002, d[31:16])
        `CHK("partner", 10'h302, {amp_pw, tx_sel, ons})
        tx_on <= 1'b0;
        rx_on <= 1'b1;
        tick();
        `CHK("rx amp/act", 2'h0, {amp_out, txact})
        `CHK("rx route", 4'h0, {st_o, st_oe_n, te_o, te_oe_n})
        `CHK("rx partner", 2'h2, {rx_sel, amp_pw})
        rx_on <= 1'b0;
        tx_on <= 1'b1;
        g_dat <= 2'h0;
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            wr(pa_mux_pkg::FUNC_SEL_ADDR,
               {15'h0, m[1], 1'b0, m[0], 14'h0});
            tick();
            `CHK("mode pins", m, {te_o, st_o})
            `CHK("mode oe_n", ~m, {te_oe_n, st_oe_n})
        end
        stop_test();
    end

    initial begin
        #(100 * 3000);
        n_mismatch++;
        stop_test();
    end
endmodule

`default_nettype wire
